// ### src/pcg_pkg.sv
package pcg_pkg;

    // Register byte offsets.
    localparam logic [11:0] OFF_SER_RUN   = 12'h104;
    localparam logic [11:0] OFF_PORT_RUN  = 12'h108;
    localparam logic [11:0] OFF_SER_SLP   = 12'h114;
    localparam logic [11:0] OFF_PORT_SLP  = 12'h118;
    localparam logic [11:0] OFF_SER_DSL   = 12'h124;
    localparam logic [11:0] OFF_PORT_DSL  = 12'h128;
    localparam logic [11:0] OFF_RUN_CFG   = 12'h060;
    localparam logic [11:0] OFF_IRQ_STS   = 12'h200;
    localparam logic [11:0] OFF_IRQ_MSK   = 12'h204;

    // Reset value and writable bits of each register.
    localparam logic [31:0] GATE_RST      = 32'h0000_0000;
    localparam logic [31:0] SER_WMASK     = 32'h0007_1037;
    localparam logic [31:0] PORT_WMASK    = 32'h0000_00FF;
    localparam logic [31:0] CFG_WMASK     = 32'h0000_0001;
    localparam logic [31:0] IRQ_WMASK     = 32'h0000_0003;

    // Field positions in the serial and timer gating register, then the port width and the control and status bits.
    localparam int          SER_U0        = 0;
    localparam int          SER_U1        = 1;
    localparam int          SER_U2        = 2;
    localparam int          SER_RSVD      = 3;
    localparam int          SER_S0        = 4;
    localparam int          SER_S1        = 5;
    localparam int          SER_I2C       = 12;
    localparam int          SER_T0        = 16;
    localparam int          SER_T1        = 17;
    localparam int          SER_T2        = 18;
    localparam int          PORT_BITS     = 8;
    localparam int          AUTO_GATE_BIT = 0;
    localparam int          IRQ_FAULT_BIT = 0;
    localparam int          IRQ_MODE_BIT  = 1;

    // Gated units: nine serial and timer units, then ports A to H.
    localparam int          SER_UNITS     = 9;
    localparam int          UNITS         = 17;
    localparam int          UNIT_IDX_W    = 5;

    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef enum logic [1:0] {
        PCG_RUN   = 2'b00,
        PCG_SLEEP = 2'b01,
        PCG_DEEP  = 2'b11
    } pcg_mode_t;

endpackage

// ### src/pcg_clk_gate.sv
`timescale 1ns/100ps
module pcg_clk_gate (
    input  wire logic clk,
    input  wire logic en,
    output logic      gclk
);
    logic en_lat;

    // Glitch-free gate.
    // The enable only changes while the clock is low, so no runt pulse can pass.
    always_latch begin
        if (!clk) begin
            en_lat <= en;
        end
    end

    assign gclk = clk & en_lat;
endmodule // pcg_clk_gate

// ### src/pcg_top.sv
`timescale 1ns/100ps
module pcg_top
    import pcg_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  sleep_req,
    input  wire logic                  deepsleep_req,
    input  wire logic                  periph_acc_valid,
    input  wire logic [UNIT_IDX_W-1:0] periph_acc_unit,
    output logic                       periph_fault,
    output logic [UNITS-1:0]           unit_clk_en,
    output logic [UNITS-1:0]           unit_gclk,
    output logic [1:0]                 power_mode,
    output logic                       irq
);
    logic [11:0]     awaddr_q;
    logic            aw_held_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;
    logic            w_held_q;
    logic            bvalid_q;
    logic [1:0]      bresp_q;
    logic            rvalid_q;
    logic [1:0]      rresp_q;
    logic [31:0]     rdata_q;
    logic [11:0]     rd_addr_q;
    logic            wr_go;
    logic            wr_hit;
    logic            ar_fire;
    logic [31:0]     ser_run_q;
    logic [31:0]     ser_slp_q;
    logic [31:0]     ser_dsl_q;
    logic [31:0]     port_run_q;
    logic [31:0]     port_slp_q;
    logic [31:0]     port_dsl_q;
    logic [31:0]     run_cfg_q;
    logic [31:0]     irq_sts_q;
    logic [31:0]     irq_sts_d;
    logic [31:0]     irq_msk_q;
    logic [31:0]     rd_mux;
    logic            rd_hit;
    pcg_mode_t       mode_q;
    pcg_mode_t       mode_d;
    logic [UNITS-1:0] unit_en_q;
    logic [UNITS-1:0] unit_en_d;
    logic            fault_q;
    logic            auto_gate_select;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res & wmask;
    endfunction

    function automatic logic [SER_UNITS-1:0] ser_units(input logic [31:0] r);
        return {r[SER_T2], r[SER_T1], r[SER_T0], r[SER_I2C], r[SER_S1], r[SER_S0],
                r[SER_U2], r[SER_U1], r[SER_U0]};
    endfunction

    // Write channel: address and data are taken independently and held.
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign wr_go         = aw_held_q && w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_comb begin
        unique case (awaddr_q)
            OFF_SER_RUN, OFF_SER_SLP, OFF_SER_DSL, OFF_PORT_RUN, OFF_PORT_SLP,
            OFF_PORT_DSL, OFF_RUN_CFG, OFF_IRQ_STS, OFF_IRQ_MSK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ser_run_q  <= GATE_RST;
            ser_slp_q  <= GATE_RST;
            ser_dsl_q  <= GATE_RST;
            port_run_q <= GATE_RST;
            port_slp_q <= GATE_RST;
            port_dsl_q <= GATE_RST;
        end else if (wr_go) begin
            if (awaddr_q == OFF_SER_RUN) ser_run_q <= merge(ser_run_q, wdata_q, wstrb_q, SER_WMASK);
            if (awaddr_q == OFF_SER_SLP) ser_slp_q <= merge(ser_slp_q, wdata_q, wstrb_q, SER_WMASK);
            if (awaddr_q == OFF_SER_DSL) ser_dsl_q <= merge(ser_dsl_q, wdata_q, wstrb_q, SER_WMASK);
            if (awaddr_q == OFF_PORT_RUN) port_run_q <= merge(port_run_q, wdata_q, wstrb_q, PORT_WMASK);
            if (awaddr_q == OFF_PORT_SLP) port_slp_q <= merge(port_slp_q, wdata_q, wstrb_q, PORT_WMASK);
            if (awaddr_q == OFF_PORT_DSL) port_dsl_q <= merge(port_dsl_q, wdata_q, wstrb_q, PORT_WMASK);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            run_cfg_q <= GATE_RST;
            irq_msk_q <= GATE_RST;
        end else if (wr_go) begin
            if (awaddr_q == OFF_RUN_CFG) run_cfg_q <= merge(run_cfg_q, wdata_q, wstrb_q, CFG_WMASK);
            if (awaddr_q == OFF_IRQ_MSK) irq_msk_q <= merge(irq_msk_q, wdata_q, wstrb_q, IRQ_WMASK);
        end
    end

    assign auto_gate_select = run_cfg_q[AUTO_GATE_BIT];

    // Status bits: hardware set wins over a write-one clear in the same cycle.
    always_comb begin
        irq_sts_d = irq_sts_q;
        if (wr_go && awaddr_q == OFF_IRQ_STS) begin
            irq_sts_d = irq_sts_q & ~merge(32'h0000_0000, wdata_q, wstrb_q, IRQ_WMASK);
        end
        if (fault_q) irq_sts_d[IRQ_FAULT_BIT] = 1'b1;
        if (mode_d != mode_q) irq_sts_d[IRQ_MODE_BIT] = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_sts_q <= GATE_RST;
        end else begin
            irq_sts_q <= irq_sts_d;
        end
    end

    assign irq = |(irq_sts_q & irq_msk_q);

    // Read channel: one read at a time, answered the cycle after address is taken.
    assign s_axi_arready = !rvalid_q;
    assign ar_fire       = s_axi_arvalid && !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            OFF_SER_RUN:  rd_mux = ser_run_q;
            OFF_SER_SLP:  rd_mux = ser_slp_q;
            OFF_SER_DSL:  rd_mux = ser_dsl_q;
            OFF_PORT_RUN: rd_mux = port_run_q;
            OFF_PORT_SLP: rd_mux = port_slp_q;
            OFF_PORT_DSL: rd_mux = port_dsl_q;
            OFF_RUN_CFG:  rd_mux = run_cfg_q;
            OFF_IRQ_STS:  rd_mux = irq_sts_q;
            OFF_IRQ_MSK:  rd_mux = irq_msk_q;
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
            rd_addr_q <= 12'h000;
        end else if (ar_fire) begin
            rvalid_q  <= 1'b1;
            rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_q   <= rd_mux;
            rd_addr_q <= s_axi_araddr;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Power mode follows the core's requests, stepping through sleep on the way down.
    always_comb begin
        unique case (mode_q)
            PCG_RUN:   mode_d = (sleep_req || deepsleep_req) ? PCG_SLEEP : PCG_RUN;
            PCG_SLEEP: mode_d = deepsleep_req ? PCG_DEEP : (sleep_req ? PCG_SLEEP : PCG_RUN);
            PCG_DEEP:  mode_d = deepsleep_req ? PCG_DEEP : (sleep_req ? PCG_SLEEP : PCG_RUN);
            default:   mode_d = PCG_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= PCG_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign power_mode = mode_q;

    always_comb begin
        unit_en_d = {port_run_q[PORT_BITS-1:0], ser_units(ser_run_q)};
        if (auto_gate_select && mode_q == PCG_SLEEP) begin
            unit_en_d = {port_slp_q[PORT_BITS-1:0], ser_units(ser_slp_q)};
        end else if (auto_gate_select && mode_q == PCG_DEEP) begin
            unit_en_d = {port_dsl_q[PORT_BITS-1:0], ser_units(ser_dsl_q)};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            unit_en_q <= '0;
        end else begin
            unit_en_q <= unit_en_d;
        end
    end

    assign unit_clk_en = unit_en_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            fault_q <= 1'b0;
        end else if (periph_acc_valid) begin
            fault_q <= (periph_acc_unit >= UNIT_IDX_W'(UNITS)) || !unit_en_q[periph_acc_unit];
        end else begin
            fault_q <= 1'b0;
        end
    end

    assign periph_fault = fault_q;

    for (genvar g = 0; g < UNITS; g++) begin : g_gate
        pcg_clk_gate u_gate (
            .clk  (clk),
            .en   (unit_en_q[g]),
            .gclk (unit_gclk[g])
        );
    end

    a_reset_all_off: assert property (
        @(posedge clk) $fell(rst) |-> (unit_en_q == '0 && port_run_q == GATE_RST
                                      && port_slp_q == GATE_RST))
        else $error("gating state not cleared by reset");

    a_fault_gated: assert property (
        @(posedge clk) disable iff (rst)
        periph_acc_valid && periph_acc_unit < UNIT_IDX_W'(UNITS)
            && !unit_en_q[periph_acc_unit] |=> periph_fault ##1 irq_sts_q[IRQ_FAULT_BIT])
        else $error("access to unclocked unit did not fault");

    a_open_no_fault: assert property (
        @(posedge clk) disable iff (rst)
        periph_acc_valid && periph_acc_unit < UNIT_IDX_W'(UNITS)
            && unit_en_q[periph_acc_unit] |=> !periph_fault)
        else $error("access to clocked unit faulted");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (rst)
        s_axi_rvalid && (rd_addr_q == OFF_PORT_RUN || rd_addr_q == OFF_PORT_SLP)
            |-> s_axi_rdata[31:PORT_BITS] == '0)
        else $error("reserved port gating bits read nonzero");

    a_port_write: assert property (
        @(posedge clk) disable iff (rst)
        wr_go && awaddr_q == OFF_PORT_RUN && wstrb_q[0]
            |=> port_run_q[PORT_BITS-1:0] == $past(wdata_q[PORT_BITS-1:0])
                ##1 unit_en_q[UNITS-1:SER_UNITS] == port_run_q[PORT_BITS-1:0]
                    || mode_q != PCG_RUN || $past(mode_q) != PCG_RUN)
        else $error("port gating write not applied");

    a_sleep_select: assert property (
        @(posedge clk) disable iff (rst)
        auto_gate_select && mode_q == PCG_SLEEP
            |=> unit_en_q[UNITS-1:SER_UNITS] == $past(port_slp_q[PORT_BITS-1:0]))
        else $error("sleep gating copy not applied in sleep");

    a_no_auto_run: assert property (
        @(posedge clk) disable iff (rst)
        !auto_gate_select |=> unit_en_q == $past({port_run_q[PORT_BITS-1:0],
                                                  ser_units(ser_run_q)}))
        else $error("run gating not kept without automatic gating");

    a_serial_bits: assert property (
        @(posedge clk) disable iff (rst)
        wr_go && awaddr_q == OFF_SER_RUN && wstrb_q[0]
            |=> ser_run_q[SER_U2:SER_U0] == $past(wdata_q[SER_U2:SER_U0])
                && ser_run_q[SER_RSVD] == 1'b0)
        else $error("serial gating bits not written correctly");

    a_sleep_port: assert property (
        @(posedge clk) disable iff (rst)
        wr_go && awaddr_q == OFF_PORT_SLP && wstrb_q[0]
            |=> port_slp_q == {24'h000000, $past(wdata_q[PORT_BITS-1:0])})
        else $error("sleep port gating write not applied");
endmodule // pcg_top

// ### bench/pcg_core_model.sv
`timescale 1ns/100ps
module pcg_core_model
    import pcg_pkg::*;
(
    input  wire logic             clk,
    output logic                  acc_valid,
    output logic [UNIT_IDX_W-1:0] acc_unit,
    input  wire logic             fault
);

    initial begin
        acc_valid = 1'b0;
        acc_unit  = '0;
    end

    // One access cycle; the unit index toggles once the access is over.
    task automatic access(input logic [UNIT_IDX_W-1:0] unit, output logic faulted);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_unit  <= unit;
        @(posedge clk);
        acc_valid <= 1'b0;
        acc_unit  <= ~unit;
        @(negedge clk);
        faulted = fault;
    endtask

endmodule // pcg_core_model

// ### bench/peripheral_clock_gating_tb_top.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("Error %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module peripheral_clock_gating_tb_top
    import pcg_pkg::*;
;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic [11:0]           awaddr = '0;
    logic                  awvalid = 1'b0;
    logic                  awready;
    logic [31:0]           wdata = '0;
    logic [3:0]            wstrb = 4'hF;
    logic                  wvalid = 1'b0;
    logic                  wready;
    logic [1:0]            bresp;
    logic                  bvalid;
    logic                  bready = 1'b0;
    logic [11:0]           araddr = '0;
    logic                  arvalid = 1'b0;
    logic                  arready;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  rvalid;
    logic                  rready = 1'b0;
    logic                  sleep_req = 1'b0;
    logic                  deepsleep_req = 1'b0;
    logic                  acc_valid;
    logic [UNIT_IDX_W-1:0] acc_unit;
    logic                  fault;
    logic [UNITS-1:0]      unit_clk_en;
    logic [UNITS-1:0]      unit_gclk;
    logic [1:0]            power_mode;
    logic                  irq;
    int                    bad_count = 0;
    int                    tests_run = 0;
    int                    ser_pos[9] = '{SER_U0, SER_U1, SER_U2, SER_S0, SER_S1,
                                          SER_I2C, SER_T0, SER_T1, SER_T2};
    logic [11:0]           offs[9] = '{OFF_SER_RUN, OFF_SER_SLP, OFF_SER_DSL, OFF_PORT_RUN,
                                       OFF_PORT_SLP, OFF_PORT_DSL, OFF_RUN_CFG, OFF_IRQ_STS,
                                       OFF_IRQ_MSK};

    always #20 clk = ~clk;

    pcg_top i_pcg_top (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_req(sleep_req), .deepsleep_req(deepsleep_req),
        .periph_acc_valid(acc_valid), .periph_acc_unit(acc_unit),
        .periph_fault(fault), .unit_clk_en(unit_clk_en), .unit_gclk(unit_gclk),
        .power_mode(power_mode), .irq(irq)
    );

    pcg_core_model i_pcg_core_model (
        .clk(clk), .acc_valid(acc_valid), .acc_unit(acc_unit), .fault(fault)
    );

    task automatic give_verdict();
        $display("Checks run %0d, errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic timed_out();
        bad_count++;
        $display("Error bus wait expected answer seen none");
        give_verdict();
    endtask

    // Handshakes are judged at the falling edge, where all inputs have settled.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] resp);
        logic aw_hit;
        logic w_hit;
        logic b_hit;
        int   n;
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            aw_hit = awvalid && awready;
            w_hit  = wvalid && wready;
            b_hit  = bvalid && bready;
            resp   = bresp;
            @(posedge clk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            if (b_hit) begin
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) timed_out();
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
        logic ar_hit;
        logic r_hit;
        int   n;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            ar_hit = arvalid && arready;
            r_hit  = rvalid && rready;
            d      = rdata;
            resp   = rresp;
            @(posedge clk);
            if (ar_hit) arvalid <= 1'b0;
            if (r_hit) begin
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) timed_out();
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] resp;
        axi_wr(a, d, 4'hF, resp);
        `CHK("write response", RESP_OKAY, resp)
        @(negedge clk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  resp;
        axi_rd(a, d, resp);
        `CHK("read response", RESP_OKAY, resp)
        `CHK("read data", exp, d)
    endtask

    task automatic gclk_chk(input logic [UNITS-1:0] exp);
        @(posedge clk);
        #5;
        `CHK("gated clock high phase", exp, unit_gclk)
        @(negedge clk);
        #5;
        `CHK("gated clock low phase", {UNITS{1'b0}}, unit_gclk)
    endtask

    task automatic mode_chk(input logic [1:0] m, input logic [UNITS-1:0] en);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK("power mode", m, power_mode)
        `CHK("unit enables", en, unit_clk_en)
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        timed_out();
    end

    initial begin
        logic [31:0] d;
        logic [31:0] ser_all;
        logic [1:0]  resp;
        logic        flt;
        int          i;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK("enables after reset", {UNITS{1'b0}}, unit_clk_en)
        `CHK("irq after reset", 1'b0, irq)
        foreach (offs[k]) rd_chk(offs[k], 32'h00000000);
        rd_chk(OFF_PORT_RUN, 32'h00000000);
        rd_chk(OFF_PORT_SLP, 32'h00000000);
        gclk_chk({UNITS{1'b0}});
        ser_all = 32'h00000000;
        for (i = 0; i < SER_UNITS; i++) begin
            ser_all |= 32'h00000001 << ser_pos[i];
            wr(OFF_SER_RUN, 32'h00000001 << ser_pos[i]);
            `CHK("serial unit enable", 17'h00001 << i, unit_clk_en)
        end
        wr(OFF_SER_RUN, 32'h00000000);
        for (i = 0; i < PORT_BITS; i++) begin
            wr(OFF_PORT_RUN, 32'h00000001 << i);
            `CHK("port unit enable", 17'h00200 << i, unit_clk_en)
        end
        gclk_chk(17'h10000);
        wr(OFF_SER_RUN, 32'hFFFFFFFF);
        rd_chk(OFF_SER_RUN, ser_all);
        wr(OFF_PORT_RUN, 32'hFFFFFFFF);
        rd_chk(OFF_PORT_RUN, 32'h000000FF);
        axi_wr(OFF_PORT_RUN, 32'h00000000, 4'h0, resp);
        rd_chk(OFF_PORT_RUN, 32'h000000FF);
        // Software clears one timer bit by read-modify-write, keeping the rest.
        axi_rd(OFF_SER_RUN, d, resp);
        wr(OFF_SER_RUN, d & ~(32'h00000001 << SER_T2));
        rd_chk(OFF_SER_RUN, ser_all & ~(32'h00000001 << SER_T2));
        axi_wr(12'h300, 32'h00000001, 4'hF, resp);
        `CHK("unmapped write response", RESP_SLVERR, resp)
        axi_rd(12'h300, d, resp);
        `CHK("unmapped read response", RESP_SLVERR, resp)
        `CHK("unmapped read data", 32'h00000000, d)
        wr(OFF_PORT_RUN, 32'h000000FE);
        wr(OFF_IRQ_MSK, 32'h00000001);
        i_pcg_core_model.access(5'h09, flt);
        `CHK("fault on gated port", 1'b1, flt)
        @(negedge clk);
        `CHK("fault pulse ends", 1'b0, fault)
        `CHK("irq on fault", 1'b1, irq)
        rd_chk(OFF_IRQ_STS, 32'h00000001);
        wr(OFF_IRQ_STS, 32'h00000001);
        `CHK("irq after clear", 1'b0, irq)
        i_pcg_core_model.access(5'h0A, flt);
        `CHK("no fault on clocked port", 1'b0, flt)
        i_pcg_core_model.access(5'h11, flt);
        `CHK("fault on missing unit", 1'b1, flt)
        wr(OFF_IRQ_MSK, 32'h00000000);
        `CHK("irq masked", 1'b0, irq)
        wr(OFF_IRQ_STS, 32'h00000001);
        wr(OFF_SER_RUN, 32'h00000000);
        wr(OFF_PORT_RUN, 32'h000000FF);
        wr(OFF_PORT_SLP, 32'h00000005);
        wr(OFF_PORT_DSL, 32'h0000000A);
        wr(OFF_SER_SLP, 32'h00000001 << SER_S0);
        wr(OFF_SER_DSL, 32'h00000001 << SER_T2);
        @(posedge clk);
        sleep_req <= 1'b1;
        mode_chk(PCG_SLEEP, 17'h1FE00);
        wr(OFF_RUN_CFG, 32'h00000001);
        `CHK("sleep enables", 17'h00A08, unit_clk_en)
        @(posedge clk);
        deepsleep_req <= 1'b1;
        mode_chk(PCG_DEEP, 17'h01500);
        @(posedge clk);
        sleep_req     <= 1'b0;
        deepsleep_req <= 1'b0;
        for (i = 0; i < 10 && power_mode !== PCG_RUN; i++) @(negedge clk);
        @(negedge clk);
        `CHK("run mode back", PCG_RUN, power_mode)
        `CHK("run enables back", 17'h1FE00, unit_clk_en)
        axi_rd(OFF_IRQ_STS, d, resp);
        `CHK("mode change status", 1'b1, d[IRQ_MODE_BIT])
        give_verdict();
    end

endmodule // peripheral_clock_gating_tb_top
